// ### hw/batt_switch_params.svh
// constants for the battery switch state controller
`ifndef BATT_SWITCH_PARAMS_SVH
`define BATT_SWITCH_PARAMS_SVH
`define BSW_CLK_PERIOD_NS     10
`define BSW_OSC_PERIOD_NS     4000000
`define BSW_PERIOD_CYCLES     (`BSW_OSC_PERIOD_NS / `BSW_CLK_PERIOD_NS)
`define BSW_SLOTS_LOG2        6
`define BSW_OVCH_PERSIST_MS   8
`define BSW_OSC_PERIOD_MS     4
`define BSW_OVCH_PERSIST_PER  (`BSW_OVCH_PERSIST_MS / `BSW_OSC_PERIOD_MS)
`define BSW_OVCH_DELAY_PER    1
`define BSW_OFF_CTRL          4'h0
`define BSW_OFF_STATE         4'h4
`define BSW_OFF_IRQ_STATUS    4'h8
`define BSW_OFF_IRQ_MASK      4'hC
`define BSW_CTRL_ENABLE_BIT   0
`define BSW_CTRL_RESET        1'h1
`define BSW_IRQ_STATE_CHANGE  0
`define BSW_IRQ_SHORT         1
`define BSW_IRQ_OVCH_CUTOFF   2
`define BSW_IRQ_CHARGER       3
`define BSW_IRQ_WIDTH         4
`define BSW_SLOT_LAST         6'h3F
`define BSW_SLOT_CYC1_ON_END  6'h07
`define BSW_SLOT_CYC7_OFF     6'h38
`endif

// ### hw/batt_switch_pkg.sv
// types for the battery switch state controller
package batt_switch_pkg;
  typedef enum logic [4:0] {
    SW_OFF  = 5'b00001,
    SW_ON   = 5'b00010,
    SW_CYC7 = 5'b00100,
    SW_CYC1 = 5'b01000,
    SW_HIGH = 5'b10000
  } sw_state_type;
endpackage

// ### hw/battery_switch_state_control.sv
// battery disconnect switch state machine with avalon-mm register slave
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`include "batt_switch_params.svh"
`timescale 1ns/1ps
`default_nettype none
module battery_switch_state_control #(
  parameter int unsigned PERIOD_CYCLES = `BSW_PERIOD_CYCLES,
  parameter int unsigned OVCH_DELAY_PER = `BSW_OVCH_DELAY_PER
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_upper_over_discharged,
  input  wire logic                      i_upper_overcharged,
  input  wire logic                      i_lower_over_discharged,
  input  wire logic                      i_lower_overcharged,
  input  wire logic                      i_pack_undervoltage,
  input  wire logic                      i_charger_present,
  input  wire logic                      i_charger_reversed,
  input  wire logic                      i_load_current_nonzero,
  input  wire logic                      i_load_short,
  input  wire logic                      i_center_tap_open,
  input  wire logic [3:0]                i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  output logic                           o_switch_gate_drive,
  output logic                           o_irq
);
  import batt_switch_pkg::*;

  localparam int unsigned SLOT_CYCLES = PERIOD_CYCLES >> `BSW_SLOTS_LOG2;

  logic        rst_meta_q, rst_n_q;
  logic [9:0]  in_meta_q, in_sync_q;
  logic [31:0] tick_cnt_q;
  logic [5:0]  slot_q;
  sw_state_type state_q, state_d;
  logic        gate_q, short_latch_q, chg_off_q, enable_q;
  logic [1:0]  ovch_persist_q;
  logic [7:0]  ovch_delay_q;
  logic [`BSW_IRQ_WIDTH-1:0] irq_status_q, irq_mask_q, irq_event;
  logic [31:0] rdata_q;
  logic        wait_q, irq_q;

  // pins from the analog side are asynchronous
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      in_meta_q <= 10'h000;
      in_sync_q <= 10'h000;
    end else begin
      in_meta_q <= {i_upper_over_discharged, i_upper_overcharged, i_lower_over_discharged,
                    i_lower_overcharged, i_pack_undervoltage, i_charger_present,
                    i_charger_reversed, i_load_current_nonzero, i_load_short,
                    i_center_tap_open};
      in_sync_q <= in_meta_q;
    end
  end

  wire cell_over_discharged = in_sync_q[9] | in_sync_q[7];
  wire cell_overcharged     = in_sync_q[8] | in_sync_q[6];
  wire pack_undervoltage    = in_sync_q[5];
  wire charger_now          = in_sync_q[4];
  wire charger_reversed     = in_sync_q[3];
  wire load_nonzero         = in_sync_q[2];
  wire load_short           = in_sync_q[1];
  wire tap_open             = in_sync_q[0];

  // time base: 64 slots per 4 ms period
  wire slot_tick   = (tick_cnt_q == SLOT_CYCLES - 1);
  wire period_tick = slot_tick && (slot_q == `BSW_SLOT_LAST);

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= 32'h0000_0000;
      slot_q     <= 6'h00;
    end else begin
      tick_cnt_q <= slot_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (slot_tick) slot_q <= slot_q + 6'h01;
    end
  end

  wire cycling = (state_q == SW_CYC7) || (state_q == SW_CYC1) || (state_q == SW_HIGH);
  // charger as seen in the open slot; while cycling only that reading counts
  wire charger_eff = cycling ? chg_off_q : charger_now;
  wire ovch_qualified = (ovch_persist_q == 2'(`BSW_OVCH_PERSIST_PER));
  wire ovch_expired   = ovch_qualified && (ovch_delay_q >= 8'(OVCH_DELAY_PER));
  wire short_any      = load_short || short_latch_q;

  always_comb begin
    state_d = SW_ON;
    if (!enable_q) begin
      state_d = SW_OFF;
    end else if (short_any) begin
      // a short opens the switch even during open-tap undervoltage charging
      state_d = SW_OFF;
    end else if (tap_open) begin
      state_d = (pack_undervoltage && charger_eff) ? SW_CYC1 : SW_OFF;
    end else if (pack_undervoltage) begin
      state_d = charger_eff ? SW_CYC1 : SW_OFF;
    end else if (cell_over_discharged) begin
      state_d = charger_eff ? SW_CYC7 : SW_OFF;
    end else if (cell_overcharged) begin
      if (charger_eff) begin
        state_d = ovch_expired ? SW_OFF : state_q;
      end else begin
        state_d = load_nonzero ? SW_HIGH : SW_OFF;
      end
    end else if (charger_reversed) begin
      state_d = SW_OFF;
    end
  end

  // gate follows state and slot; cycling states open for part of each period
  logic gate_d;
  always_comb begin
    case (state_q)
      SW_ON:   gate_d = 1'b1;
      SW_CYC7: gate_d = (slot_q < `BSW_SLOT_CYC7_OFF);
      SW_CYC1: gate_d = (slot_q <= `BSW_SLOT_CYC1_ON_END);
      SW_HIGH: gate_d = (slot_q != `BSW_SLOT_LAST);
      default: gate_d = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q       <= SW_OFF;
      gate_q        <= 1'b0;
      short_latch_q <= 1'b0;
      chg_off_q     <= 1'b0;
      ovch_persist_q <= 2'b00;
      ovch_delay_q   <= 8'h00;
    end else begin
      gate_q <= gate_d;
      // short held until the load is fully removed
      if (load_short) short_latch_q <= 1'b1;
      else if (period_tick && !load_nonzero) short_latch_q <= 1'b0;
      if (slot_tick && (slot_q == `BSW_SLOT_LAST)) chg_off_q <= charger_now;
      if (period_tick) begin
        state_q <= state_d;
        if (!cell_overcharged) ovch_persist_q <= 2'b00;
        else if (!ovch_qualified) ovch_persist_q <= ovch_persist_q + 2'b01;
        // delay restarts together with the persistence count once overcharge goes
        if (!cell_overcharged || !ovch_qualified) ovch_delay_q <= 8'h00;
        else if (!ovch_expired) ovch_delay_q <= ovch_delay_q + 8'h01;
      end
    end
  end

  // events: set beats a simultaneous write-one clear
  assign irq_event[`BSW_IRQ_STATE_CHANGE] = period_tick && (state_d != state_q);
  assign irq_event[`BSW_IRQ_SHORT]        = load_short && !short_latch_q;
  assign irq_event[`BSW_IRQ_OVCH_CUTOFF]  = period_tick && ovch_expired && state_q != SW_OFF
                                            && state_d == SW_OFF;
  assign irq_event[`BSW_IRQ_CHARGER]      = slot_tick && (slot_q == `BSW_SLOT_LAST)
                                            && (chg_off_q != charger_now);

  // avalon slave: one wait cycle, then a single cycle with waitrequest low
  wire req    = i_avs_read || i_avs_write;
  wire accept = req && !wait_q;
  wire wr     = accept && i_avs_write;
  wire sel_ctrl  = (i_avs_address == `BSW_OFF_CTRL);
  wire sel_state = (i_avs_address == `BSW_OFF_STATE);
  wire sel_ists  = (i_avs_address == `BSW_OFF_IRQ_STATUS);
  wire sel_imask = (i_avs_address == `BSW_OFF_IRQ_MASK);
  wire [31:0] state_word = {16'h0000, load_short, load_nonzero, charger_reversed, charger_now,
                            pack_undervoltage, cell_overcharged, cell_over_discharged, tap_open,
                            short_latch_q, gate_q, ovch_persist_q, 4'h0} | {27'h0, state_q};
  wire [31:0] rdata_d = sel_ctrl  ? {31'h0, enable_q} :
                        sel_state ? state_word :
                        sel_ists  ? {28'h0, irq_status_q} :
                        sel_imask ? {28'h0, irq_mask_q} : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q       <= 1'b1;
      rdata_q      <= 32'h0000_0000;
      enable_q     <= `BSW_CTRL_RESET;
      irq_status_q <= 4'h0;
      irq_mask_q   <= 4'h0;
      irq_q        <= 1'b0;
    end else begin
      wait_q <= !(req && wait_q);
      if (req && wait_q) rdata_q <= rdata_d;
      if (wr && sel_ctrl) enable_q <= i_avs_writedata[`BSW_CTRL_ENABLE_BIT];
      if (wr && sel_imask) irq_mask_q <= i_avs_writedata[3:0];
      irq_status_q <= (irq_status_q & ~((wr && sel_ists) ? i_avs_writedata[3:0] : 4'h0))
                      | irq_event;
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  assign o_avs_readdata      = rdata_q;
  assign o_avs_waitrequest   = wait_q;
  assign o_switch_gate_drive = gate_q;
  assign o_irq               = irq_q;

  property p_state_at_period;
    @(posedge i_clk) disable iff (!rst_n_q) !period_tick |=> $stable(state_q);
  endproperty
  a_state_at_period: assert property (p_state_at_period) else $error("state moved off tick");

  property p_short_off;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && load_short |=> state_q == SW_OFF;
  endproperty
  a_short_off: assert property (p_short_off) else $error("short left switch on");

  property p_tap_off;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && tap_open && !pack_undervoltage |=> state_q == SW_OFF;
  endproperty
  a_tap_off: assert property (p_tap_off) else $error("open tap left switch on");

  property p_undervolt_chg;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && enable_q && pack_undervoltage && charger_eff && !load_short
      && !short_latch_q |=> state_q == SW_CYC1;
  endproperty
  a_undervolt_chg: assert property (p_undervolt_chg) else $error("undervoltage charge not 1/8");

  property p_overdis_chg;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && enable_q && !tap_open && !short_any && !pack_undervoltage
      && cell_over_discharged && charger_eff |=> state_q == SW_CYC7;
  endproperty
  a_overdis_chg: assert property (p_overdis_chg) else $error("over-discharge charge not 7/8");

  property p_normal_on;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && enable_q && !tap_open && !short_any && !pack_undervoltage
      && !cell_over_discharged && !cell_overcharged && !charger_reversed |=> state_q == SW_ON;
  endproperty
  a_normal_on: assert property (p_normal_on) else $error("normal cells not on");

  property p_reverse_off;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && charger_reversed && !cell_over_discharged && !cell_overcharged
      && !pack_undervoltage && !tap_open |=> state_q == SW_OFF;
  endproperty
  a_reverse_off: assert property (p_reverse_off) else $error("reversed charger not off");

  property p_cyc1_gate;
    @(posedge i_clk) disable iff (!rst_n_q)
      state_q == SW_CYC1 && slot_q > `BSW_SLOT_CYC1_ON_END |=> !gate_q;
  endproperty
  a_cyc1_gate: assert property (p_cyc1_gate) else $error("1/8 gate on in off slots");

  property p_ovch_persist;
    @(posedge i_clk) disable iff (!rst_n_q)
      ovch_delay_q != 8'h00 |-> ovch_persist_q == 2'(`BSW_OVCH_PERSIST_PER);
  endproperty
  a_ovch_persist: assert property (p_ovch_persist) else $error("delay began too early");

  property p_high_on;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && enable_q && !short_any && !tap_open && !pack_undervoltage
      && !cell_over_discharged && cell_overcharged && !charger_eff && load_nonzero
      |=> state_q == SW_HIGH;
  endproperty
  a_high_on: assert property (p_high_on) else $error("loaded overcharge not high duty");

  property p_high_gate;
    @(posedge i_clk) disable iff (!rst_n_q)
      state_q == SW_HIGH && slot_q == `BSW_SLOT_LAST |=> !gate_q;
  endproperty
  a_high_gate: assert property (p_high_gate) else $error("high duty gate never opens");

  property p_cyc7_gate;
    @(posedge i_clk) disable iff (!rst_n_q)
      state_q == SW_CYC7 && slot_q >= `BSW_SLOT_CYC7_OFF |=> !gate_q;
  endproperty
  a_cyc7_gate: assert property (p_cyc7_gate) else $error("7/8 gate on in open slots");

  property p_gate_on;
    @(posedge i_clk) disable iff (!rst_n_q)
      state_q == SW_ON |=> gate_q;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("steady on gate dropped");

  property p_chg_ovch_off;
    @(posedge i_clk) disable iff (!rst_n_q)
      period_tick && enable_q && !short_any && !tap_open && !pack_undervoltage
      && !cell_over_discharged && cell_overcharged && charger_eff && ovch_expired
      |=> state_q == SW_OFF;
  endproperty
  a_chg_ovch_off: assert property (p_chg_ovch_off) else $error("overcharge kept charging");
endmodule // battery_switch_state_control
`default_nettype wire

// ### tb/charger_load_model.sv
// behavioural charger, load and sense stand-in at the far side of the switch
`timescale 1ns/1ps
`default_nettype none
module charger_load_model (
  input  wire logic i_gate,
  input  wire logic i_charger_on,
  input  wire logic i_charger_flip,
  input  wire logic i_load_on,
  input  wire logic i_short_on,
  output logic      o_charger_present,
  output logic      o_charger_reversed,
  output logic      o_load_nonzero,
  output logic      o_load_short
);
  // detect comparator sees the charger whatever the switch does
  assign o_charger_present  = i_charger_on & ~i_charger_flip;
  assign o_charger_reversed = i_charger_flip;
  // a connected load is still seen with the switch open
  assign o_load_nonzero     = i_load_on | i_short_on;
  // short current only flows through a conducting switch
  assign o_load_short       = i_short_on & i_gate;
endmodule // charger_load_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the battery switch state controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int per = 640;
  localparam logic [9:0] uod = 10'h001, uoc = 10'h002, lod = 10'h004, loc = 10'h008;
  localparam logic [9:0] undv = 10'h010, chg = 10'h020, rev = 10'h040, ld = 10'h080;
  localparam logic [9:0] sh = 10'h100, tap = 10'h200;
  logic i_clk, i_reset_n, avs_read, avs_write, waitreq, gate, irq;
  logic [3:0]  avs_addr;
  logic [31:0] avs_wdata, avs_rdata, r;
  logic [9:0]  cond;
  logic        chg_p, rev_p, ld_nz, ld_sh;
  int          errors, checks;

  battery_switch_state_control #(.PERIOD_CYCLES(per), .OVCH_DELAY_PER(1)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_upper_over_discharged(cond[0]), .i_upper_overcharged(cond[1]),
    .i_lower_over_discharged(cond[2]), .i_lower_overcharged(cond[3]),
    .i_pack_undervoltage(cond[4]), .i_charger_present(chg_p), .i_charger_reversed(rev_p),
    .i_load_current_nonzero(ld_nz), .i_load_short(ld_sh), .i_center_tap_open(cond[9]),
    .i_avs_address(avs_addr), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_wdata), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(waitreq), .o_switch_gate_drive(gate), .o_irq(irq));

  charger_load_model far_u (
    .i_gate(gate), .i_charger_on(cond[5]), .i_charger_flip(cond[6]),
    .i_load_on(cond[7]), .i_short_on(cond[8]), .o_charger_present(chg_p),
    .o_charger_reversed(rev_p), .o_load_nonzero(ld_nz), .o_load_short(ld_sh));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic summarize;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    avs_addr <= a;
    avs_wdata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    if (n >= 100) chk("bus_timeout", 32'h0000_0000, 32'h0000_0001);
    r = avs_rdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // apply conditions, let wp periods pass, then count gate-on cycles over one period
  task automatic run(input logic [9:0] c, input int wp, input int eg, input logic [3:0] es);
    int g;
    g = 0;
    @(posedge i_clk);
    cond <= c;
    repeat (wp * per) @(posedge i_clk);
    repeat (per) begin
      @(posedge i_clk);
      if (gate === 1'b1) g++;
    end
    chk("gate_count", 32'(eg), 32'(g));
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("state", {28'h0000000, es}, {28'h0000000, r[3:0]});
  endtask

  initial begin
    // about 95k cycles, some 21k above the roughly 74k cycles that the sequence needs
    #950000;
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    summarize();
  end

  initial begin
    errors = 0;
    checks = 0;
    i_reset_n = 1'b0;
    cond = 10'h000;
    avs_addr = 4'h0;
    avs_wdata = 32'h0000_0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    bus(1'b0, 4'h0, 32'h0); chk("ctrl_reset", 32'h0000_0001, r);
    bus(1'b0, 4'hC, 32'h0); chk("mask_reset", 32'h0000_0000, r);
    bus(1'b0, 4'h1, 32'h0); chk("unmapped", 32'h0000_0000, r);
    run(chg | ld, 5, 640, 4'h2);
    run(uoc | ld, 5, 630, 4'h0);
    run(uoc, 5, 0, 4'h1);
    run(ld, 5, 640, 4'h2);
    run(ld | sh, 5, 0, 4'h1);
    run(10'h000, 5, 640, 4'h2);
    run(lod | chg | ld, 5, 560, 4'h4);
    run(lod | ld, 5, 0, 4'h1);
    run(undv | chg, 5, 80, 4'h8);
    run(undv | chg | tap, 5, 80, 4'h8);
    run(tap | ld, 5, 0, 4'h1);
    run(chg | ld, 5, 640, 4'h2);
    run(uoc | loc | chg | ld, 0, 640, 4'h2);
    run(uoc | loc | chg | ld, 5, 0, 4'h1);
    run(uod | ld, 5, 0, 4'h1);
    run(chg, 5, 640, 4'h2);
    run(chg | rev, 5, 0, 4'h1);
    run(chg, 5, 640, 4'h2);
    bus(1'b1, 4'h0, 32'h0000_0000);
    run(chg, 5, 0, 4'h1);
    bus(1'b1, 4'hC, 32'h0000_0001);
    repeat (3) @(posedge i_clk);
    chk("irq_set", 32'h1, {31'h0, irq});
    bus(1'b0, 4'h8, 32'h0); chk("status_set", 32'h0000_000F, r);
    bus(1'b1, 4'h8, 32'h0000_000F);
    repeat (3) @(posedge i_clk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    bus(1'b0, 4'h8, 32'h0); chk("status", 32'h0, r);
    bus(1'b1, 4'hC, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0001);
    run(chg, 5, 640, 4'h2);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
